// *** hw/skip_gate_pkg.sv ***
// Package for the skip-linked conversion trigger gate.
// Assumes a single 125 MHz clock and an AXI4-Lite register master.
package skip_gate_pkg;

   // Byte offsets of the registers on the bus
   localparam logic [7:0] SKIP_SETTING_OFF = 8'h00; // Skip counts and enables
   localparam logic [7:0] SKIP_COUNTER_OFF = 8'h04; // Counter readback
   localparam logic [7:0] SKIP_MODE_OFF = 8'h08; // Function select
   localparam logic [7:0] TRIGGER_LINK_OFF = 8'h0C; // Link bits
   localparam logic [7:0] STATUS_OFF = 8'h10; // Mode, windows

   // Field positions in the skip setting register
   localparam int TROUGH_COUNT_LSB = 0;
   localparam int TROUGH_EN_BIT = 3;
   localparam int CREST_COUNT_LSB = 4;
   localparam int CREST_EN_BIT = 7;

   // Field positions in the trigger link register
   localparam int LINK_B_TROUGH_BIT = 4;
   localparam int LINK_B_CREST_BIT = 5;
   localparam int LINK_A_TROUGH_BIT = 6;
   localparam int LINK_A_CREST_BIT = 7;

   // Reset values
   localparam logic [7:0] SKIP_SETTING_RST = 8'h00;
   localparam logic [15:0] TRIGGER_LINK_RST = 16'h0000;
   localparam logic [2:0] COUNT_RST = 3'h0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Decoded skip setting
   typedef struct packed {
      logic crest_skip_enable;
      logic [2:0] crest_skip_count;
      logic trough_skip_enable;
      logic [2:0] trough_skip_count;
   } skip_setting_t;

   // Four link bits per timer pair
   typedef struct packed {
      logic link_a_crest;
      logic link_a_trough;
      logic link_b_crest;
      logic link_b_trough;
   } link_bits_t;

   // Timer events presented to the gate
   typedef struct packed {
      logic crest_interrupt;
      logic trough_interrupt;
      logic adc_request_a;
      logic adc_request_b;
   } timer_events_t;

   // Write channel states, one-hot
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_COLLECT = 3'b010,
      WR_RESP = 3'b100
   } wr_state_t;

endpackage

// *** hw/skip_trigger_gate.sv ***
// Gate that drops conversion start requests in step with crest and
// trough interrupt skipping of a complementary PWM timer pair.
// Assumes timer event inputs are synchronous one-cycle pulses on aclk.
// Assumes software keeps the link bits clear outside complementary PWM.
//
// Operation
// - Crest and trough interrupts skippable, up to seven
// - Four link bits gate request A/B by window
// - Window high only while counter equals count
// - Linked to both: pass if either window
// - Crest-only link: pass only in crest window
// - Trough-only link: pass only in trough window
// - Select bit one clears setting and counters
// - Counter increments per event, wraps at count
// - Counters hold when the timer stops
// - Setting holds two 3-bit counts, two enables
// - Count of zero means no skipping
// - Clearing both enables clears skip counters
`timescale 1ns/10ps

module skip_trigger_gate (
   input wire logic aclk,
   input wire logic aresetn,
   // Timer pair events and mode
   input wire skip_gate_pkg::timer_events_t timer_events,
   input wire logic complementary_pwm_mode,
   // Gated triggers to the converter
   output logic adc_trigger_a,
   output logic adc_trigger_b,
   // Skipped interrupt outputs to the interrupt controller
   output logic crest_irq,
   output logic trough_irq,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // Software registers
   skip_gate_pkg::skip_setting_t skip_setting_reg_r; // Counts and enables
   logic [15:0] trigger_link_reg_r; // Link bits in low byte
   logic skip_function_select_r; // One selects the other skip function
   logic [2:0] crest_cnt_r; // Crest skip counter
   logic [2:0] trough_cnt_r; // Trough skip counter
   skip_gate_pkg::link_bits_t links; // Decoded link bits
   logic crest_window; // Crest request-enabled window
   logic trough_window; // Trough request-enabled window
   // Window and gating terms, all combinational from the registers
   logic crest_active; // Crest skipping in force
   logic trough_active; // Trough skipping in force
   logic pass_a; // Request A allowed through
   logic pass_b; // Request B allowed through

   // Write channel
   skip_gate_pkg::wr_state_t wr_state_r; // One-hot write state
   logic [7:0] awaddr_r; // Latched write address
   logic [31:0] wdata_r; // Latched write data
   logic [3:0] wstrb_r; // Latched strobes
   logic aw_have_r; // Address captured
   logic w_have_r; // Data captured
   logic wr_commit; // One-cycle register update strobe

   // Link bits sit in the low byte; the high byte is plain storage
   // that the gate never reads
   assign links = '{
      link_a_crest: trigger_link_reg_r[skip_gate_pkg::LINK_A_CREST_BIT],
      link_a_trough: trigger_link_reg_r[skip_gate_pkg::LINK_A_TROUGH_BIT],
      link_b_crest: trigger_link_reg_r[skip_gate_pkg::LINK_B_CREST_BIT],
      link_b_trough: trigger_link_reg_r[skip_gate_pkg::LINK_B_TROUGH_BIT]
   };

   // Skipping is live only with its enable set and a nonzero count
   assign crest_active = skip_setting_reg_r.crest_skip_enable &&
      (skip_setting_reg_r.crest_skip_count != 3'h0);
   assign trough_active = skip_setting_reg_r.trough_skip_enable &&
      (skip_setting_reg_r.trough_skip_count != 3'h0);

   // Windows open while each counter sits at its programmed count
   assign crest_window = crest_active &&
      (crest_cnt_r == skip_setting_reg_r.crest_skip_count);
   assign trough_window = trough_active &&
      (trough_cnt_r == skip_setting_reg_r.trough_skip_count);

   // Linked windows are ORed; an unlinked request passes freely
   // A linked window that never opens blocks its request for good
   always_comb begin
      // Request A
      if (links.link_a_crest && links.link_a_trough) begin
         // Either window lets the request through
         pass_a = crest_window || trough_window;
      end else if (links.link_a_crest) begin
         pass_a = crest_window;
      end else if (links.link_a_trough) begin
         pass_a = trough_window;
      end else begin
         // No link: the request ignores both windows
         pass_a = 1'b1;
      end
      // Request B
      if (links.link_b_crest && links.link_b_trough) begin
         // Either window lets the request through
         pass_b = crest_window || trough_window;
      end else if (links.link_b_crest) begin
         pass_b = crest_window;
      end else if (links.link_b_trough) begin
         pass_b = trough_window;
      end else begin
         // No link: the request ignores both windows
         pass_b = 1'b1;
      end
   end

   // Gated trigger pulses, one cycle each; the window is sampled before
   // the counter moves so a coincident event sees the old window
   // Registered so the converter never sees a combinational glitch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         adc_trigger_a <= 1'b0;
         adc_trigger_b <= 1'b0;
      end else begin
         // A request lasts one cycle, so the trigger does too
         adc_trigger_a <= timer_events.adc_request_a && pass_a;
         adc_trigger_b <= timer_events.adc_request_b && pass_b;
      end
   end

   // Skipped interrupts: forwarded only when the counter is at the count
   // or when skipping is off for that source
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crest_irq <= 1'b0;
         trough_irq <= 1'b0;
      end else begin
         crest_irq <= timer_events.crest_interrupt &&
            (!crest_active || crest_window);
         trough_irq <= timer_events.trough_interrupt &&
            (!trough_active || trough_window);
      end
   end

   // Crest counter: counts only on events in complementary PWM mode, so it holds
   // while the timer is stopped; cleared by select bit or by dropping both enables
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crest_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (skip_function_select_r) begin
         // The other skip function owns the pair; start from zero
         crest_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (!skip_setting_reg_r.crest_skip_enable &&
                   !skip_setting_reg_r.trough_skip_enable) begin
         // Both enables off: software is about to change the count
         crest_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (timer_events.crest_interrupt && crest_active &&
                   complementary_pwm_mode) begin
         if (crest_cnt_r == skip_setting_reg_r.crest_skip_count) begin
            // Count reached: this event was serviced, start over
            crest_cnt_r <= skip_gate_pkg::COUNT_RST;
         end else begin
            crest_cnt_r <= crest_cnt_r + 3'h1;
         end
      end
   end

   // Trough counter, same scheme as the crest counter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trough_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (skip_function_select_r) begin
         // The other skip function owns the pair; start from zero
         trough_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (!skip_setting_reg_r.crest_skip_enable &&
                   !skip_setting_reg_r.trough_skip_enable) begin
         // Both enables off: software is about to change the count
         trough_cnt_r <= skip_gate_pkg::COUNT_RST;
      end else if (timer_events.trough_interrupt && trough_active &&
                   complementary_pwm_mode) begin
         if (trough_cnt_r == skip_setting_reg_r.trough_skip_count) begin
            // Count reached: this event was serviced, start over
            trough_cnt_r <= skip_gate_pkg::COUNT_RST;
         end else begin
            trough_cnt_r <= trough_cnt_r + 3'h1;
         end
      end
   end

   // Write channel: address and data accepted in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Readies stay low in reset and rise one edge after release
         wr_state_r <= skip_gate_pkg::WR_IDLE;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= skip_gate_pkg::RESP_OKAY;
      end else begin
         unique case (wr_state_r)
            // Open both ready lines
            skip_gate_pkg::WR_IDLE: begin
               s_axi_awready <= 1'b1;
               s_axi_wready <= 1'b1;
               aw_have_r <= 1'b0;
               w_have_r <= 1'b0;
               wr_state_r <= skip_gate_pkg::WR_COLLECT;
            end
            // Catch each half and close its ready as it is taken
            skip_gate_pkg::WR_COLLECT: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  awaddr_r <= s_axi_awaddr;
                  aw_have_r <= 1'b1;
                  s_axi_awready <= 1'b0;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wdata_r <= s_axi_wdata;
                  wstrb_r <= s_axi_wstrb;
                  w_have_r <= 1'b1;
                  s_axi_wready <= 1'b0;
               end
               if (aw_have_r && w_have_r) begin
                  // Only the writable offsets answer OKAY
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= (awaddr_r == skip_gate_pkg::SKIP_SETTING_OFF ||
                     awaddr_r == skip_gate_pkg::SKIP_MODE_OFF ||
                     awaddr_r == skip_gate_pkg::TRIGGER_LINK_OFF) ?
                     skip_gate_pkg::RESP_OKAY : skip_gate_pkg::RESP_SLVERR;
                  wr_state_r <= skip_gate_pkg::WR_RESP;
               end
            end
            // Hold the response until the master takes it
            // bvalid is always high here, so bready alone retires it
            skip_gate_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_r <= skip_gate_pkg::WR_IDLE;
               end
            end
         endcase
      end
   end

   // Registers update in the cycle the response is raised
   // Commit lasts one cycle since the state leaves collection at once
   assign wr_commit = (wr_state_r == skip_gate_pkg::WR_COLLECT) &&
      aw_have_r && w_have_r;

   // Skip setting; forced clear while the other function is selected.
   // Safe write timing is left to software.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_setting_reg_r <= skip_gate_pkg::SKIP_SETTING_RST;
      end else if (skip_function_select_r) begin
         skip_setting_reg_r <= skip_gate_pkg::SKIP_SETTING_RST;
      end else if (wr_commit && wstrb_r[0] &&
                   awaddr_r == skip_gate_pkg::SKIP_SETTING_OFF) begin
         skip_setting_reg_r <= wdata_r[7:0];
      end
   end

   // Select bit and link register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_function_select_r <= 1'b0;
         trigger_link_reg_r <= skip_gate_pkg::TRIGGER_LINK_RST;
      end else if (wr_commit) begin
         // Select bit: one hands the pair to the other skip function
         if (awaddr_r == skip_gate_pkg::SKIP_MODE_OFF && wstrb_r[0]) begin
            skip_function_select_r <= wdata_r[0];
         end
         // Link register honours both low byte strobes
         if (awaddr_r == skip_gate_pkg::TRIGGER_LINK_OFF) begin
            if (wstrb_r[0]) begin
               trigger_link_reg_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
               trigger_link_reg_r[15:8] <= wdata_r[15:8];
            end
         end
      end
   end

   // Read channel: one-cycle answer, held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= skip_gate_pkg::RESP_OKAY;
      end else if (s_axi_rvalid) begin
         // Data stays put until the master takes it
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= skip_gate_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            skip_gate_pkg::SKIP_SETTING_OFF:
               s_axi_rdata <= {24'h000000, skip_setting_reg_r};
            // Counters read back as two nibbles, top bit of each zero
            skip_gate_pkg::SKIP_COUNTER_OFF:
               s_axi_rdata <= {24'h000000, 1'b0, crest_cnt_r, 1'b0,
                  trough_cnt_r};
            skip_gate_pkg::SKIP_MODE_OFF:
               s_axi_rdata <= {31'h00000000, skip_function_select_r};
            skip_gate_pkg::TRIGGER_LINK_OFF:
               s_axi_rdata <= {16'h0000, trigger_link_reg_r};
            skip_gate_pkg::STATUS_OFF:
               s_axi_rdata <= {29'h00000000, complementary_pwm_mode,
                  crest_window, trough_window};
            default: begin
               // Unmapped address answers an error with zero data
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= skip_gate_pkg::RESP_SLVERR;
            end
         endcase
      end else begin
         // Idle: reopen the address channel; one read at a time
         s_axi_arready <= 1'b1;
      end
   end

endmodule // skip_trigger_gate

// *** tb/adc_start_model.sv ***
// Converter start model: counts conversions started by the gate.
// Assumes one-cycle trigger pulses on aclk.
`timescale 1ns/10ps
module adc_start_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic start_a,
   input wire logic start_b,
   output logic [15:0] starts_a,
   output logic [15:0] starts_b
);
   // Every pulse starts one conversion; a level would count once per cycle held
   always_ff @(posedge aclk) begin
      starts_a <= aresetn ? starts_a + 16'(start_a) : 16'h0000;
      starts_b <= aresetn ? starts_b + 16'(start_b) : 16'h0000;
   end
endmodule // adc_start_model

// *** tb/adc_trigger_interrupt_skip_gate_bench.sv ***
// Bench for the skip trigger gate: bus task, random events, queues.
// Assumes package, checker and converter model compile first.
`timescale 1ns/10ps
module adc_trigger_interrupt_skip_gate_bench;
   logic aclk = 1'b0; // 125 MHz clock
   logic aresetn = 1'b0; // Low for 20 cycles
   logic mode = 1'b1; // Complementary PWM running
   skip_gate_pkg::timer_events_t ev_r = '0; // Event pulses
   skip_gate_pkg::skip_setting_t set = '0; // Setting mirror
   skip_gate_pkg::link_bits_t lk = '0; // Link mirror
   logic [7:0] addr = 8'h00; // Shared, reads and writes never overlap
   logic [31:0] wdata = 32'h00000000, rdata;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, trig_a, trig_b;
   logic c_irq, t_irq; // Forwarded interrupts
   logic [1:0] bresp, rresp;
   logic [15:0] n_a, n_b, exp_a = 16'h0000, exp_b = 16'h0000;
   logic [2:0] cc = 3'h0, tc = 3'h0; // Expected skip counters
   logic [33:0] rq[$]; // Expected read answers
   logic [1:0] bq[$], tq[$], iq[$]; // Write answers, triggers, irqs
   integer seed = 32'h2B839759;
   int err_count = 0, checks = 0, cyc = 0;
   skip_trigger_gate i_skip_trigger_gate (
      .aclk(aclk), .aresetn(aresetn), .timer_events(ev_r),
      .complementary_pwm_mode(mode), .adc_trigger_a(trig_a),
      .adc_trigger_b(trig_b), .crest_irq(c_irq), .trough_irq(t_irq),
      .s_axi_awaddr(addr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bre), .s_axi_araddr(addr), .s_axi_arvalid(arv),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rre));
   adc_start_model i_adc_start_model (.aclk(aclk), .aresetn(aresetn),
      .start_a(trig_a), .start_b(trig_b), .starts_a(n_a), .starts_b(n_b));
   always #4 aclk = ~aclk; // 8 ns period
   // Hang guard, far above the run length
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [33:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("err_count %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // One bus transfer; each channel is dropped only once taken
   task automatic bus(input logic rd, input logic [7:0] a,
      input logic [31:0] d, input logic [1:0] r);
      if (rd) rq.push_back({r, d});
      else bq.push_back(r);
      @(posedge aclk);
      addr <= a;
      wdata <= d;
      awv <= !rd;
      wv <= !rd;
      bre <= !rd;
      arv <= rd;
      rre <= rd;
      do begin
         @(posedge aclk);
         if (awready) awv <= 1'b0;
         if (wready) wv <= 1'b0;
         if (arready) arv <= 1'b0;
      end while (!(bvalid && bre) && !(rvalid && rre));
      bre <= 1'b0;
      rre <= 1'b0;
   endtask
   // Random pulses; windows are taken before the counters move
   task automatic run_ev(input int n);
      logic [31:0] r;
      logic ce, te, ra, rb, ca, ta, cw, tw, pa, pb, ci, ti;
      repeat (n) begin
         @(posedge aclk);
         r = $random(seed);
         ce = r[2:0] == 3'h0;
         te = r[5:3] == 3'h0;
         // Compare points sit clear of crest and trough instants
         ra = r[6] && !ce && !te;
         rb = r[7] && !ce && !te;
         ev_r <= {ce, te, ra, rb};
         ca = set.crest_skip_enable && set.crest_skip_count != 3'h0;
         ta = set.trough_skip_enable && set.trough_skip_count != 3'h0;
         cw = ca && cc == set.crest_skip_count;
         tw = ta && tc == set.trough_skip_count;
         pa = ra && (lk.link_a_crest && cw || lk.link_a_trough && tw
            || !lk.link_a_crest && !lk.link_a_trough);
         pb = rb && (lk.link_b_crest && cw || lk.link_b_trough && tw
            || !lk.link_b_crest && !lk.link_b_trough);
         ci = ce && (!ca || cw);
         ti = te && (!ta || tw);
         if (pa || pb) tq.push_back({pa, pb});
         if (ci || ti) iq.push_back({ci, ti});
         exp_a += pa;
         exp_b += pb;
         // Counters move only while skipping is live for the source
         if (mode && ce && ca)
            cc = (cc == set.crest_skip_count) ? 3'h0 : cc + 3'h1;
         if (mode && te && ta)
            tc = (tc == set.trough_skip_count) ? 3'h0 : tc + 3'h1;
      end
      @(posedge aclk);
      ev_r <= '0;
   endtask
   // New setting; enables cleared first so the counters restart
   task automatic prog();
      logic [31:0] r;
      r = $random(seed);
      set = r[7:0];
      lk = r[11:8];
      if (!set.crest_skip_enable && !set.trough_skip_enable) lk = '0;
      bus(1'b0, 8'h00, 32'h00000000, 2'h0);
      cc = 3'h0;
      tc = 3'h0;
      bus(1'b0, 8'h00, {24'h000000, set}, 2'h0);
      bus(1'b0, 8'h0C, {24'h000000, lk, 4'h0}, 2'h0);
      bus(1'b1, 8'h00, {24'h000000, set}, 2'h0);
   endtask
   // Monitor: each answer or trigger retires the oldest note
   always @(posedge aclk) begin
      if (aresetn && bvalid && bre)
         chk("bresp", bresp, bq.pop_front());
      if (aresetn && rvalid && rre)
         chk("read", {rresp, rdata}, rq.pop_front());
      if (aresetn && (trig_a || trig_b))
         chk("trigger", {trig_a, trig_b}, tq.pop_front());
      if (aresetn && (c_irq || t_irq))
         chk("irq", {c_irq, t_irq}, iq.pop_front());
   end
   initial begin
      skip_gate_pkg::link_bits_t keep;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      bus(1'b1, 8'h00, 32'h00000000, 2'h0);
      bus(1'b1, 8'h0C, 32'h00000000, 2'h0);
      bus(1'b1, 8'h14, 32'h00000000, 2'h2);
      bus(1'b0, 8'h04, 32'h00000077, 2'h2);
      for (int i = 0; i < 12; i++) begin
         prog();
         run_ev(60);
         // Timer stopped: links off, counters must hold
         if (i % 3 == 2) begin
            keep = lk;
            lk = '0;
            bus(1'b0, 8'h0C, 32'h00000000, 2'h0);
            mode <= 1'b0;
            run_ev(30);
            mode <= 1'b1;
            lk = keep;
            bus(1'b0, 8'h0C, {24'h000000, lk, 4'h0}, 2'h0);
            run_ev(30);
         end
         bus(1'b1, 8'h04, {24'h000000, 1'b0, cc, 1'b0, tc}, 2'h0);
      end
      bus(1'b0, 8'h08, 32'h00000001, 2'h0);
      bus(1'b1, 8'h00, 32'h00000000, 2'h0);
      bus(1'b1, 8'h04, 32'h00000000, 2'h0);
      repeat (4) @(posedge aclk);
      chk("starts a", n_a, exp_a);
      chk("starts b", n_b, exp_b);
      chk("left", rq.size() + bq.size() + tq.size() + iq.size(), 0);
      close_out();
   end
endmodule // adc_trigger_interrupt_skip_gate_bench
bind skip_trigger_gate skip_gate_chk i_skip_gate_chk (
   .aclk(aclk), .aresetn(aresetn), .timer_events(timer_events),
   .adc_trigger_a(adc_trigger_a), .adc_trigger_b(adc_trigger_b),
   .crest_irq(crest_irq), .trough_irq(trough_irq),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid));

// *** tb/skip_gate_chk.sv ***
// Port checker for the skip trigger gate.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module skip_gate_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire skip_gate_pkg::timer_events_t timer_events,
   input wire logic adc_trigger_a,
   input wire logic adc_trigger_b,
   input wire logic crest_irq,
   input wire logic trough_irq,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // A gated trigger only echoes a request one cycle late
   AST_TRIG_A: assert property (
      adc_trigger_a |-> $past(timer_events.adc_request_a))
      else $error("trigger a without request");
   AST_TRIG_B: assert property (
      adc_trigger_b |-> $past(timer_events.adc_request_b))
      else $error("trigger b without request");
   // Forwarded interrupts need their event
   AST_CREST_IRQ: assert property (
      crest_irq |-> $past(timer_events.crest_interrupt))
      else $error("crest irq without event");
   AST_TROUGH_IRQ: assert property (
      trough_irq |-> $past(timer_events.trough_interrupt))
      else $error("trough irq without event");
   // Reset leaves no trigger and no crest irq behind
   AST_QUIET: assert property (
      $rose(aresetn) |-> !adc_trigger_a && !adc_trigger_b && !crest_irq)
      else $error("output active after reset");
   // Register bus answers
   AST_B_ANSWER: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write answer late");
   AST_B_DONE: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && !s_axi_awready)
      else $error("write answer not retired");
   AST_R_ANSWER: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   cover property (adc_trigger_a && adc_trigger_b);
   cover property (timer_events.adc_request_a ##1 !adc_trigger_a);
   cover property (crest_irq);
endmodule // skip_gate_chk
